// ### spi_pkg.sv
// shared constants, types and helper functions of the serial engine
// assumes a single 40 MHz clock and a 32-bit transfer word

package spi_pkg;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_HZ    = 40_000_000;
  localparam int US_PER_S  = 1_000_000;
  localparam int US_CYCLES = CLK_HZ / US_PER_S;   // cycles in one microsecond
  localparam int TICK_W    = 6;
  localparam logic [TICK_W-1:0] US_LAST = TICK_W'(US_CYCLES - 1);

  // ----------------------------------------
  // widths, depths and reset values
  // ----------------------------------------
  localparam int WORD_W     = 32;
  localparam int FIFO_DEPTH = 16;
  localparam int IDX_W      = 6;
  localparam int CNT_W      = 16;
  localparam logic [6:0] MAX_BITS    = 7'h20;
  localparam logic [2:0] MIN_SAMPLES = 3'h1;
  localparam logic       RST_CS_PIN  = 1'b1;    // inactive level of a low-active select

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {MODE0, MODE1, MODE2, MODE3} spi_mode_t;
  typedef enum logic [1:0] {S_IDLE, S_RUN, S_LOAD, S_SLAVE} state_t;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // zero or oversize bit counts fall back to the full word
  function automatic logic [6:0] eff_bits(input logic [5:0] b);
    eff_bits = (b == 6'h00 || {1'b0, b} > MAX_BITS) ? MAX_BITS : {1'b0, b};
  endfunction : eff_bits

  function automatic logic [2:0] eff_samples(input logic [2:0] n);
    eff_samples = (n == 3'h0) ? MIN_SAMPLES : n;
  endfunction : eff_samples

  // word position of the idx-th bit on the wire
  function automatic logic [4:0] bit_pos(input logic [IDX_W-1:0] idx,
                                         input logic [6:0] bits, input logic lsb);
    logic [6:0] p;
    p = 7'(bits - 7'h01 - {1'b0, idx});
    bit_pos = lsb ? idx[4:0] : p[4:0];
  endfunction : bit_pos

  // more than half of the samples were high
  function automatic logic majority(input logic [2:0] ones, input logic [2:0] n);
    majority = {ones, 1'b0} > {1'b0, n};
  endfunction : majority

  function automatic logic [CNT_W-1:0] max3(input logic [CNT_W-1:0] a,
                                            input logic [CNT_W-1:0] b,
                                            input logic [CNT_W-1:0] c);
    logic [CNT_W-1:0] m;
    m = (a > b) ? a : b;
    max3 = (m > c) ? m : c;
  endfunction : max3

endpackage : spi_pkg

// ### stream_if.sv
// valid/ready word stream between the engine and its buffer
// assumes producer and consumer share one clock

interface stream_if #(parameter int W = 32);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : stream_if

// ### us_tick.sv
// microsecond enable pulse from the system clock
// assumes clear restarts the count so a wait starts aligned

module us_tick (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic clear,
  output logic      tick
);
  typedef struct packed {
    logic [spi_pkg::TICK_W-1:0] cnt;
    logic                       tick;
  } tick_s_t;

  tick_s_t s_reg;
  tick_s_t s_next;

  // ----------------------------------------
  // divider
  // ----------------------------------------
  always_comb
  begin
    s_next = s_reg;
    s_next.tick = 1'b0;
    if (clear)
      s_next.cnt = '0;
    else if (s_reg.cnt == spi_pkg::US_LAST)
    begin
      s_next.cnt = '0;
      s_next.tick = 1'b1;
    end
    else
      s_next.cnt = s_reg.cnt + 1'b1;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign tick = s_reg.tick;
endmodule : us_tick

// ### tx_fifo.sv
// flip-flop word buffer with valid/ready on both sides
// assumes the reader may stall; full shows as in_s.ready low

module tx_fifo #(
  parameter int W = 32,
  parameter int D = 16
) (
  input  wire logic clk,
  input  wire logic resetn,
  stream_if.snk     in_s,
  stream_if.src     out_s
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
  } fifo_s_t;

  fifo_s_t s_reg;
  fifo_s_t s_next;
  logic    wr;
  logic    rd;

  // honest flags straight from the fill count
  assign in_s.ready  = s_reg.cnt != (AW+1)'(D);
  assign out_s.valid = s_reg.cnt != '0;
  assign out_s.data  = s_reg.mem[s_reg.rp];
  assign wr = in_s.valid && in_s.ready;
  assign rd = out_s.valid && out_s.ready;

  // ----------------------------------------
  // pointers and storage
  // ----------------------------------------
  always_comb
  begin
    s_next = s_reg;
    if (wr)
    begin
      s_next.mem[s_reg.wp] = in_s.data;
      s_next.wp = AW'(s_reg.wp + 1'b1);
    end
    if (rd)
      s_next.rp = AW'(s_reg.rp + 1'b1);
    if (wr && !rd)
      s_next.cnt = s_reg.cnt + 1'b1;
    else if (rd && !wr)
      s_next.cnt = s_reg.cnt - 1'b1;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end
endmodule : tx_fifo

// ### spi_engine.sv
// full-duplex serial engine, master or slave, with a 16-word send buffer
// assumes link pins are asynchronous and get synchronised here
// Notes on behaviour
// - master drives the clock unless slave mode; slave follows external clock
// - master clock high and low times in microseconds, zero by default
// - select is active for the whole transfer at a chosen level
// - after the last bit of a master transfer the latch output pulses active once
// - sample indicator is high while incoming data is being sampled
// - sample on falling edge by default, rising edge when selected
// - transfer length is configurable, up to and defaulting to 32 bits
// - each bit is sampled several times and resolved by majority
// - clock rests at a configurable idle level between transfers
// - after select asserts, wait a set number of microseconds
// - keep a set interval between data change and next clock edge
// - most significant bit first by default, least first when chosen
// - four mode codes set idle level and sampling edge together
// - separate lines carry incoming and outgoing data
// - each transfer sends a word and returns the word received
// - runs at a chosen half-period, as fast as possible when none

module spi_engine (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        slave_mode,
  input  wire logic        use_mode,
  input  wire logic [1:0]  mode,
  input  wire logic        idle_level,
  input  wire logic        sample_rise,
  input  wire logic        lsb_first,
  input  wire logic        cs_active_level,
  input  wire logic        load_active_level,
  input  wire logic [5:0]  bit_count,
  input  wire logic [2:0]  sample_count,
  input  wire logic [7:0]  clock_high_us,
  input  wire logic [7:0]  clock_low_us,
  input  wire logic [7:0]  enable_delay_us,
  input  wire logic [7:0]  data_hold_cycles,
  input  wire logic [15:0] baud_half_cycles,
  input  wire logic        tx_valid,
  output logic             tx_ready,
  input  wire logic [31:0] tx_data,
  output logic [31:0]      rx_data,
  output logic             done,
  input  wire logic        sclk_in,
  output logic             sclk_out,
  output logic             sclk_oe_n,
  input  wire logic        cs_in,
  output logic             cs_out,
  output logic             cs_oe_n,
  output logic             serial_out,
  input  wire logic        serial_in_line,
  output logic             load_out,
  output logic             sample_indicator
);
  typedef struct packed {
    spi_pkg::state_t           state;
    logic [31:0]               word;
    logic [31:0]               rx;
    logic [31:0]               rxo;
    logic [6:0]                edges;
    logic [spi_pkg::IDX_W-1:0] tx_idx;
    logic [spi_pkg::IDX_W-1:0] rx_idx;
    logic [spi_pkg::CNT_W-1:0] tmr;
    logic [7:0]                us_left;
    logic [2:0]                samp_left;
    logic [2:0]                ones;
    logic                      sclk;
    logic                      cs_act;
    logic                      cs_pin;
    logic                      load;
    logic                      load_pin;
    logic                      dout;
    logic                      done;
    logic                      din_s1;
    logic                      din_s2;
    logic                      ck_s1;
    logic                      ck_s2;
    logic                      ck_s3;
    logic                      cs_s1;
    logic                      cs_s2;
    logic                      cs_s3;
  } eng_s_t;

  eng_s_t s_reg;
  eng_s_t s_next;

  stream_if #(.W(spi_pkg::WORD_W)) wr_if ();
  stream_if #(.W(spi_pkg::WORD_W)) rd_if ();

  logic                      idle_lvl;
  logic                      samp_rise;
  logic                      first_samp;
  logic [6:0]                nbits;
  logic [2:0]                nsamp;
  logic [spi_pkg::CNT_W-1:0] ph_cyc;
  logic                      us_tk;
  logic                      tick_clr;
  logic                      pop;
  logic                      smp_edge;
  logic                      shf_edge;
  logic                      new_lvl;
  logic                      cs_now;
  logic                      cs_was;
  logic [2:0]                ones_now;

  // ----------------------------------------
  // buffer and microsecond divider
  // ----------------------------------------
  assign wr_if.valid = tx_valid;
  assign wr_if.data  = tx_data;
  assign tx_ready    = wr_if.ready;
  assign rd_if.ready = pop;

  tx_fifo #(.W(spi_pkg::WORD_W), .D(spi_pkg::FIFO_DEPTH)) u_fifo (
    .clk    (clk),
    .resetn (resetn),
    .in_s   (wr_if),
    .out_s  (rd_if)
  );

  us_tick u_tick (
    .clk    (clk),
    .resetn (resetn),
    .clear  (tick_clr),
    .tick   (us_tk)
  );

  // ----------------------------------------
  // configuration decode
  // ----------------------------------------
  // mode codes override the separate idle and edge settings
  always_comb
  begin
    idle_lvl = idle_level;
    samp_rise = sample_rise;
    if (use_mode)
    begin
      case (spi_pkg::spi_mode_t'(mode))
        spi_pkg::MODE0: begin idle_lvl = 1'b0; samp_rise = 1'b1; end
        spi_pkg::MODE1: begin idle_lvl = 1'b0; samp_rise = 1'b0; end
        spi_pkg::MODE2: begin idle_lvl = 1'b1; samp_rise = 1'b0; end
        default:        begin idle_lvl = 1'b1; samp_rise = 1'b1; end
      endcase
    end
  end

  // first edge samples when it moves toward the sampling level
  assign first_samp = samp_rise != idle_lvl;
  assign nbits = spi_pkg::eff_bits(bit_count);
  assign nsamp = spi_pkg::eff_samples(sample_count);
  // a phase never undercuts the hold time or the sample window; the extra cycle covers
  // the two-flop input lag, which would otherwise read the bit from before the shift edge
  assign ph_cyc = spi_pkg::max3((baud_half_cycles == 16'h0000) ? 16'h0001 : baud_half_cycles,
                                {8'h00, data_hold_cycles},
                                {13'h0000, nsamp} + 16'h0001) - 16'h0001;
  assign cs_now = s_reg.cs_s2 == cs_active_level;
  assign cs_was = s_reg.cs_s3 == cs_active_level;
  assign ones_now = s_reg.ones + {2'b00, s_reg.din_s2};

  // ----------------------------------------
  // transfer engine
  // ----------------------------------------
  always_comb
  begin
    s_next = s_reg;
    s_next.done = 1'b0;
    tick_clr = 1'b0;
    pop = 1'b0;
    smp_edge = 1'b0;
    shf_edge = 1'b0;
    new_lvl = ~s_reg.sclk;
    s_next.din_s1 = serial_in_line;
    s_next.din_s2 = s_reg.din_s1;
    s_next.ck_s1 = sclk_in;
    s_next.ck_s2 = s_reg.ck_s1;
    s_next.ck_s3 = s_reg.ck_s2;
    s_next.cs_s1 = cs_in;
    s_next.cs_s2 = s_reg.cs_s1;
    s_next.cs_s3 = s_reg.cs_s2;
    if (s_reg.tmr != '0)
      s_next.tmr = s_reg.tmr - 1'b1;
    if (s_reg.us_left != 8'h00 && us_tk)
      s_next.us_left = s_reg.us_left - 1'b1;
    case (s_reg.state)
      spi_pkg::S_IDLE:
      begin
        s_next.sclk = idle_lvl;
        s_next.cs_act = 1'b0;
        // starts only from idle, so a busy engine takes no new word
        if ((!slave_mode && rd_if.valid) || (slave_mode && cs_now && !cs_was))
        begin
          pop = rd_if.valid;
          s_next.word = rd_if.valid ? rd_if.data : '0;
          s_next.rx = '0;
          s_next.tx_idx = '0;
          s_next.rx_idx = '0;
          s_next.edges = '0;
          s_next.samp_left = '0;
          s_next.cs_act = !slave_mode;
          s_next.tmr = ph_cyc;
          s_next.us_left = enable_delay_us;
          tick_clr = 1'b1;
          s_next.state = slave_mode ? spi_pkg::S_SLAVE : spi_pkg::S_RUN;
          if (first_samp)
          begin
            s_next.dout = s_next.word[spi_pkg::bit_pos('0, nbits, lsb_first)];
            s_next.tx_idx = 6'h01;
          end
        end
      end
      spi_pkg::S_RUN:
      begin
        if (s_reg.tmr == '0 && s_reg.us_left == 8'h00)
        begin
          tick_clr = 1'b1;
          s_next.tmr = ph_cyc;
          if (s_reg.edges == {nbits[5:0], 1'b0})
          begin
            s_next.state = spi_pkg::S_LOAD;
            s_next.cs_act = 1'b0;
            s_next.load = 1'b1;
            s_next.us_left = 8'h00;
          end
          else
          begin
            s_next.sclk = new_lvl;
            s_next.edges = s_reg.edges + 1'b1;
            s_next.us_left = new_lvl ? clock_high_us : clock_low_us;
            smp_edge = new_lvl == samp_rise;
            shf_edge = !smp_edge;
          end
        end
      end
      spi_pkg::S_LOAD:
      begin
        if (s_reg.tmr == '0)
        begin
          s_next.load = 1'b0;
          s_next.done = 1'b1;
          s_next.rxo = s_reg.rx;
          s_next.state = spi_pkg::S_IDLE;
        end
      end
      default:
      begin
        // slave: edges of the synchronised external clock drive the bits
        new_lvl = s_reg.ck_s2;
        smp_edge = (s_reg.ck_s2 != s_reg.ck_s3) && (new_lvl == samp_rise);
        shf_edge = (s_reg.ck_s2 != s_reg.ck_s3) && !smp_edge;
        if (!cs_now || ({1'b0, s_reg.rx_idx} == nbits && s_reg.samp_left == 3'h0))
        begin
          s_next.done = 1'b1;
          s_next.rxo = s_reg.rx;
          s_next.state = spi_pkg::S_IDLE;
        end
      end
    endcase
    // majority window, one sample per cycle after the sampling edge
    if (s_reg.samp_left != 3'h0)
    begin
      s_next.ones = ones_now;
      s_next.samp_left = s_reg.samp_left - 1'b1;
      if (s_reg.samp_left == 3'h1)
      begin
        s_next.rx[spi_pkg::bit_pos(s_reg.rx_idx, nbits, lsb_first)] =
          spi_pkg::majority(ones_now, nsamp);
        s_next.rx_idx = s_reg.rx_idx + 1'b1;
      end
    end
    if (smp_edge)
    begin
      s_next.samp_left = nsamp;
      s_next.ones = 3'h0;
    end
    // with the first bit preloaded, the last shift edge has no bit left to put out
    if (shf_edge && {1'b0, s_reg.tx_idx} < nbits)
    begin
      s_next.dout = s_reg.word[spi_pkg::bit_pos(s_reg.tx_idx, nbits, lsb_first)];
      s_next.tx_idx = s_reg.tx_idx + 1'b1;
    end
    s_next.cs_pin = s_next.cs_act ? cs_active_level : ~cs_active_level;
    s_next.load_pin = s_next.load ? load_active_level : ~load_active_level;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_reg <= '0;
      s_reg.cs_pin <= spi_pkg::RST_CS_PIN;
    end
    else
      s_reg <= s_next;
  end

  // ----------------------------------------
  // pins and results
  // ----------------------------------------
  assign sclk_out = s_reg.sclk;
  assign sclk_oe_n = slave_mode;              // low while the master drives
  assign cs_out = s_reg.cs_pin;
  assign cs_oe_n = slave_mode;
  assign serial_out = s_reg.dout;
  assign load_out = s_reg.load_pin;
  assign sample_indicator = s_reg.samp_left != 3'h0;
  assign rx_data = s_reg.rxo;
  assign done = s_reg.done;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  property p_master_only;
    (s_reg.state == spi_pkg::S_RUN) |-> !slave_mode && !sclk_oe_n;
  endproperty
  a_master_only: assert property (p_master_only) else $error("clock run in slave mode");

  property p_idle_level;
    (s_reg.state == spi_pkg::S_IDLE) && $past(s_reg.state == spi_pkg::S_IDLE) && $stable(idle_lvl)
      && !slave_mode |-> sclk_out == idle_lvl;
  endproperty
  a_idle_level: assert property (p_idle_level) else $error("clock not at idle level");

  property p_cs_active;
    (s_reg.state == spi_pkg::S_RUN) && $stable(cs_active_level) |-> cs_out == cs_active_level;
  endproperty
  a_cs_active: assert property (p_cs_active) else $error("select inactive in transfer");

  property p_load_pulse;
    $rose(s_reg.state == spi_pkg::S_LOAD) |-> load_out == load_active_level
      ##[1:300] (done && load_out != load_active_level);
  endproperty
  a_load_pulse: assert property (p_load_pulse) else $error("latch pulse missing");

  property p_indicator;
    smp_edge |=> sample_indicator [*1] ##0 (s_reg.samp_left == nsamp);
  endproperty
  a_indicator: assert property (p_indicator) else $error("indicator not raised");

  property p_done_once;
    done |-> s_reg.state == spi_pkg::S_IDLE ##1 !done;
  endproperty
  a_done_once: assert property (p_done_once) else $error("done longer than a cycle");

  property p_enable_delay;
    ($past(s_reg.state) == spi_pkg::S_IDLE) && (s_reg.state == spi_pkg::S_RUN)
      && enable_delay_us != 8'h00 |-> $stable(sclk_out) [*8];
  endproperty
  a_enable_delay: assert property (p_enable_delay) else $error("clock before delay");

  property p_hold;
    (s_reg.state == spi_pkg::S_RUN) && $changed(serial_out) && data_hold_cycles > 8'h02
      |=> $stable(sclk_out) [*2];
  endproperty
  a_hold: assert property (p_hold) else $error("clock too soon after data");

  property p_msb_first;
    (s_reg.state == spi_pkg::S_IDLE) && pop && !slave_mode && first_samp && !lsb_first
      |=> serial_out == $past(rd_if.data[spi_pkg::bit_pos('0, nbits, 1'b0)]);
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("wrong first bit");

  c_master_done: cover property (done && !slave_mode);
  c_slave_done: cover property (done && slave_mode);
  c_lsb_vote: cover property (done && lsb_first && nsamp == 3'h3);
  c_fifo_full: cover property (!tx_ready);
endmodule : spi_engine

// ### spi_peripheral_model.sv
// behavioural serial peripheral that faces the engine in master mode
// assumes the bench tells it rest level, sampling edge, bit order and length

module spi_peripheral_model (
  input  wire logic        sclk,
  input  wire logic        sel_in,
  input  wire logic        sel_level,
  input  wire logic        serial_in,
  input  wire logic        idle,
  input  wire logic        samp_rise,
  input  wire logic        lsb,
  input  wire logic [6:0]  bits,
  input  wire logic [31:0] reply,
  output logic             data_out,
  output logic [31:0]      got
);
  timeunit 1ns;
  timeprecision 1ps;
  int   out_idx = 0;
  int   n_got = 0;
  logic first_samples;

  // the first edge samples when it is the sampling edge, so data must be ready at select
  assign first_samples = idle ^ samp_rise;

  function automatic logic reply_bit(input int i);
    if (i >= bits)
      return ~data_out;
    return lsb ? reply[i] : reply[bits - 1 - i];
  endfunction : reply_bit

  // select edges: preload the first bit if the first edge samples, or release the line to a changing value
  always @(sel_in)
  begin
    if (sel_in === sel_level)
    begin
      n_got = 0;
      got = '0;
      out_idx = 0;
      if (first_samples)
      begin
        data_out = reply_bit(0);
        out_idx = 1;
      end
    end
    else
      data_out = ~data_out;
  end

  initial data_out = 1'b0;

  task automatic take();
    if (sel_in === sel_level && n_got < bits)
    begin
      if (lsb)
        got[n_got] = serial_in;
      else
        got = {got[30:0], serial_in};
      n_got++;
    end
  endtask : take

  task automatic give();
    if (sel_in === sel_level)
    begin
      data_out = reply_bit(out_idx);
      out_idx++;
    end
  endtask : give

  // sample on one edge, shift on the other
  always @(posedge sclk)
    if (samp_rise) take(); else give();
  always @(negedge sclk)
    if (samp_rise) give(); else take();
endmodule : spi_peripheral_model

// ### configurable_spi_master_tb.sv
// self-checking bench for the serial engine with a peripheral model
// assumes 40 MHz clock, config read live and stable during a transfer

module configurable_spi_master_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, resetn, slave_mode, use_mode, idle_level, sample_rise, lsb_first, cs_active_level;
  logic load_active_level, tx_valid, sclk_in, cs_in, tb_sin, tx_ready, done, sclk_out, sclk_oe_n;
  logic cs_out, cs_oe_n, serial_out, load_out, sample_indicator, prev_load, prev_si, prev_sclk, m_out;
  logic [1:0]  mode;
  logic [5:0]  bit_count;
  logic [2:0]  sample_count;
  logic [7:0]  clock_high_us, clock_low_us, enable_delay_us, data_hold_cycles;
  logic [15:0] baud_half_cycles;
  logic [31:0] tx_data, rx_data, reply, m_got, mask;
  logic [6:0]  nbits;
  int err_count = 0, checks = 0, load_cnt, samp_cnt, cs_bad, done_cnt, last_wait;

  assign nbits = (bit_count == 6'h00 || bit_count > 6'h20) ? 7'h20 : {1'b0, bit_count};
  assign mask = (nbits == 7'h20) ? 32'hFFFFFFFF : ((32'h1 << nbits) - 32'h1);

  spi_engine i_dut (.clk(clk), .resetn(resetn), .slave_mode(slave_mode), .use_mode(use_mode),
    .mode(mode), .idle_level(idle_level), .sample_rise(sample_rise), .lsb_first(lsb_first),
    .cs_active_level(cs_active_level), .load_active_level(load_active_level), .bit_count(bit_count),
    .sample_count(sample_count), .clock_high_us(clock_high_us), .clock_low_us(clock_low_us),
    .enable_delay_us(enable_delay_us), .data_hold_cycles(data_hold_cycles),
    .baud_half_cycles(baud_half_cycles), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data),
    .rx_data(rx_data), .done(done), .sclk_in(sclk_in), .sclk_out(sclk_out), .sclk_oe_n(sclk_oe_n),
    .cs_in(cs_in), .cs_out(cs_out), .cs_oe_n(cs_oe_n), .serial_out(serial_out),
    .serial_in_line(slave_mode ? tb_sin : m_out), .load_out(load_out), .sample_indicator(sample_indicator));

  spi_peripheral_model i_peer (.sclk(sclk_out), .sel_in(cs_out), .sel_level(cs_active_level),
    .serial_in(serial_out), .idle(use_mode ? mode[1] : idle_level),
    .samp_rise(use_mode ? (mode == 2'h0 || mode == 2'h3) : sample_rise), .lsb(lsb_first),
    .bits(nbits), .reply(reply), .data_out(m_out), .got(m_got));

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // watch pins: latch pulses, sample windows, clock edges outside select, done strobes
  always @(posedge clk)
  begin
    if (load_out === load_active_level && prev_load !== load_active_level) load_cnt++;
    if (sample_indicator === 1'b1 && prev_si !== 1'b1) samp_cnt++;
    if (!slave_mode && sclk_out !== prev_sclk && cs_out !== cs_active_level) cs_bad++;
    if (done === 1'b1) done_cnt++;
    prev_load <= load_out;
    prev_si <= sample_indicator;
    prev_sclk <= sclk_out;
  end

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic final_report();
    $display("checks %0d err_count %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : final_report

  task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_word

  task automatic chk_bit(input string nm, input logic e, input logic g);
    chk_word(nm, {31'h0, e}, {31'h0, g});
  endtask : chk_bit

  task automatic wait_done(input int lim);
    for (last_wait = 0; last_wait < lim; last_wait++)
    begin
      @(posedge clk);
      #1;
      if (done === 1'b1) return;
    end
    err_count++;
    final_report();
  endtask : wait_done

  task automatic push(input logic [31:0] w);
    tx_data <= w;
    tx_valid <= 1'b1;
    repeat (50)
    begin
      @(negedge clk);
      if (tx_ready === 1'b1)
      begin
        @(posedge clk);
        tx_valid <= 1'b0;
        return;
      end
    end
    err_count++;
    final_report();
  endtask : push

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic master_xfer(input logic [31:0] w, input logic [31:0] rep);
    repeat (4) @(posedge clk);
    @(negedge clk);
    reply = rep;
    load_cnt = 0;
    samp_cnt = 0;
    cs_bad = 0;
    @(posedge clk);
    push(w);
    wait_done(20000);
    chk_word("rx_data", rep & mask, rx_data);
    chk_word("peer_word", w & mask, m_got);
    chk_word("load_pulses", 32'h1, load_cnt);
    chk_word("sample_windows", {25'h0, nbits}, samp_cnt);
    chk_word("clock_outside_select", 32'h0, cs_bad);
    chk_bit("cs_idle", ~cs_active_level, cs_out);
    chk_bit("sclk_rest", use_mode ? mode[1] : idle_level, sclk_out);
  endtask : master_xfer

  task automatic all_modes();
    for (int m = 0; m < 8; m++)
    begin
      @(posedge clk);
      mode <= 2'(m >> 1);
      lsb_first <= m[0];
      master_xfer(32'hA5C3_1E00 | 32'(m), 32'h0000_0096 ^ 32'(m << 3));
    end
  endtask : all_modes

  task automatic slow_long();
    @(posedge clk);
    {use_mode, idle_level, sample_rise, cs_active_level, load_active_level} <= 5'h0F;
    {bit_count, sample_count, baud_half_cycles} <= {6'h00, 3'h3, 16'h0004};
    {data_hold_cycles, enable_delay_us, clock_high_us} <= {8'h03, 8'h01, 8'h01};
    lsb_first <= 1'b0;
    master_xfer(32'h8123_4567, 32'hC0FF_EE01);
    chk_bit("min_duration", 1'b1, last_wait >= 40 + 32 * 40);
  endtask : slow_long

  task automatic fill_slave_drain();
    logic [7:0] so;
    int acc;
    @(posedge clk);
    {cs_active_level, load_active_level, use_mode, mode} <= 5'h04;
    {bit_count, sample_count, baud_half_cycles, clock_high_us, enable_delay_us} <= 'h0;
    bit_count <= 6'h08;
    slave_mode <= 1'b1;
    @(posedge clk);
    acc = 0;
    tx_valid <= 1'b1;
    for (int k = 0; k < 17; k++)
    begin
      tx_data <= 32'hC0 + 32'(acc);
      @(negedge clk);
      if (tx_ready === 1'b1) acc++;
      @(posedge clk);
    end
    tx_valid <= 1'b0;
    chk_word("accepted", 32'd16, acc);
    chk_bit("tx_ready_full", 1'b0, tx_ready);
    chk_bit("sclk_oe_n", 1'b1, sclk_oe_n);
    cs_in <= 1'b0;
    #300;
    for (int i = 0; i < 8; i++)
    begin
      tb_sin <= 1'(8'h3C >> (7 - i));
      #100 sclk_in <= 1'b1;
      so = {so[6:0], serial_out};
      #100 sclk_in <= 1'b0;
    end
    wait_done(200);
    chk_word("slave_rx", 32'h3C, rx_data);
    chk_word("slave_tx", 32'hC0, {24'h0, so});
    cs_in <= 1'b1;
    @(posedge clk);
    reply = 32'h5A;
    slave_mode <= 1'b0;
    // clear once the slave strobe has been counted, so only drained words remain
    @(negedge clk);
    done_cnt = 0;
    for (int t = 0; t < 20000 && done_cnt < 15; t++) @(posedge clk);
    chk_word("drained", 32'd15, done_cnt);
    chk_word("last_peer_word", 32'hCF, m_got);
    chk_bit("tx_ready_empty", 1'b1, tx_ready);
  endtask : fill_slave_drain

  initial
  begin
    {resetn, slave_mode, use_mode, mode, idle_level, sample_rise, lsb_first} = 8'h20;
    {cs_active_level, load_active_level, tx_valid, tx_data, tb_sin} = '0;
    {sclk_in, cs_in, bit_count, sample_count} = {2'h1, 6'h08, 3'h1};
    {clock_high_us, clock_low_us, enable_delay_us, data_hold_cycles, baud_half_cycles} = '0;
    reply = '0;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk_bit("cs_after_reset", 1'b1, cs_out);
    chk_bit("sclk_after_reset", 1'b0, sclk_out);
    chk_bit("sclk_oe_n_master", 1'b0, sclk_oe_n);
    chk_bit("done_idle", 1'b0, done);
    all_modes();
    slow_long();
    fill_slave_drain();
    final_report();
  end
endmodule : configurable_spi_master_tb
